// *** src/gain_loop_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef GAIN_LOOP_REGS_SVH
`define GAIN_LOOP_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_HOLDOFF 8'h04
`define OFS_DECIM 8'h08
`define OFS_SIG_GAIN 8'h0c
`define OFS_ERR_THR 8'h10
`define OFS_AVG_SCALE 8'h14
`define OFS_POLE 8'h18
`define OFS_REQ_LEVEL 8'h1c
`define OFS_GAIN_HIGH 8'h20
`define OFS_GAIN_LOW 8'h24
`define OFS_STATUS 8'h28
`define OFS_STRENGTH 8'h2c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_CHAN_SYNC 10
`define CTL_PIN_HI 9
`define CTL_PIN_LO 8
`define CTL_WLEN_HI 7
`define CTL_WLEN_LO 5
`define CTL_MODE 4
`define CTL_SYNC_NOW 3
`define CTL_INIT_SYNC 2
`define CTL_FIRST_ONLY 1
`define CTL_BYPASS 0

// ----------------------------------------
// Averaging register fields
// ----------------------------------------
`define AVG_SCALE_HI 5
`define AVG_SCALE_LO 2
`define AVG_CNT_HI 1
`define AVG_CNT_LO 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONTROL 11'h000
`define RST_HOLDOFF 16'h0001
`define RST_DECIM 12'h000
`define RST_SIG_GAIN 12'h000
`define RST_ERR_THR 12'h000
`define RST_AVG_SCALE 6'h00
`define RST_BYTE 8'h00

// ----------------------------------------
// Timing and widths
// ----------------------------------------
`define HOLDOFF_FIRE 16'h0001
`define SAMPLE_W 16

`endif

// *** src/gain_loop_pkg.sv ***
// Types shared by the gain loop control block
package gain_loop_pkg;

	// I/Q sample pair
	typedef struct packed {
		logic [15:0] i;
		logic [15:0] q;
	} iq_t;

	// Control register fields
	typedef struct packed {
		logic chan_sync;
		logic [1:0] pin_sel;
		logic [2:0] word_len;
		logic mode;
		logic sync_now;
		logic init_sync;
		logic first_only;
		logic bypass;
	} ctrl_t;

	// Parameters adopted by the loop on initialisation
	typedef struct packed {
		logic [11:0] decim;
		logic [1:0] avg_cnt;
		logic [3:0] scale;
		logic [11:0] gain;
		logic [7:0] k_high;
		logic [7:0] k_low;
		logic [7:0] pole;
	} loop_par_t;

	// Hold-off counter states
	typedef enum logic [1:0] {
		HOLD_IDLE = 2'b01,
		HOLD_COUNT = 2'b10
	} hold_state_t;

endpackage

// *** src/channel_agc_sync_control.sv ***
// Gain loop configuration, sync selection and output word shaping
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "gain_loop_regs.svh"

// Notes on behaviour
// RULE_01 - Channel-sync-select set uses channel sync
// RULE_02 - Pin-select field picks one of four pins
// RULE_03 - Word-length field sets output width 16..4
// RULE_04 - Mode bit picks signal or clipping target
// RULE_05 - Sync-now bit syncs loop, emits strength
// RULE_06 - Initialize-on-sync clears filter, loads parameters
// RULE_07 - Otherwise keep state; always emit, restart
// RULE_08 - First-sync-only ignores later sync requests
// RULE_09 - Bypass skips gain but still truncates
// RULE_10 - Hold-off counter loads, fires at one
// RULE_11 - Hold-off one immediate, zero never syncs
// RULE_12 - Decimation ratio is field plus one
// RULE_13 - Software encodes initial gain in dB/256
// RULE_14 - Threshold picks low or high loop gain
// RULE_15 - Scale 6.02 dB steps, average count+1
// RULE_16 - Pole value adopted only on initialisation
// RULE_17 - Software encodes request level in dB/64
// RULE_18 - Loop gains adopted only on initialisation
// RULE_19 - Sync during countdown reloads the counter
module channel_agc_sync_control (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] sync_pin_i,
	input wire logic chan_sync_i,
	input wire gain_loop_pkg::iq_t sample_i,
	input wire logic sample_valid_i,
	output gain_loop_pkg::iq_t sample_o,
	output logic sample_valid_o,
	output logic [15:0] strength_o,
	output logic strength_valid_o,
	output logic loop_sync_o
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Byte-lane merge of a write into a register image
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				res[b*8 +: 8] = wr[b*8 +: 8];
		end
		return res;
	endfunction

	// Keep the top bits of a word for the selected length
	function automatic logic [15:0] trunc(input logic [15:0] v,
		input logic [2:0] wl);
		logic [15:0] m;
		unique case (wl)
			3'h0: m = 16'hffff;
			3'h1: m = 16'hfff0;
			3'h2: m = 16'hffc0;
			3'h3: m = 16'hff00;
			3'h4: m = 16'hfe00;
			3'h5: m = 16'hfc00;
			3'h6: m = 16'hf800;
			3'h7: m = 16'hf000;
		endcase
		return v & m;
	endfunction

	// Magnitude of a signed sample
	function automatic logic [15:0] mag(input logic [15:0] v);
		return v[15] ? 16'(-v) : v;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	gain_loop_pkg::ctrl_t ctrl;
	logic [15:0] holdoff;
	logic [11:0] decim;
	logic [11:0] sig_gain;
	logic [11:0] err_thr;
	logic [5:0] avg_scale;
	logic [7:0] pole;
	logic [7:0] req_level;
	logic [7:0] k_high;
	logic [7:0] k_low;
	logic sync_now;
	logic synced_once;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic [31:0] rd_mux;
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land at the edge that samples ack high
	wire bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	wire [31:0] wr_img = merge(rd_mux, wb_dat_i, wb_sel_i); // Merged lanes
	wire wr_ctl = bus_wr & (wb_adr_i == `OFS_CONTROL);

	// Register write port
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl <= gain_loop_pkg::ctrl_t'(`RST_CONTROL);
			holdoff <= `RST_HOLDOFF;
			decim <= `RST_DECIM;
			sig_gain <= `RST_SIG_GAIN;
			err_thr <= `RST_ERR_THR;
			avg_scale <= `RST_AVG_SCALE;
			pole <= `RST_BYTE;
			req_level <= `RST_BYTE;
			k_high <= `RST_BYTE;
			k_low <= `RST_BYTE;
		end
		else if (bus_wr)
		begin
			unique case (wb_adr_i)
				`OFS_CONTROL: ctrl <= gain_loop_pkg::ctrl_t'(wr_img[10:0]
					& 11'h7f7); // Sync-now bit never stored
				`OFS_HOLDOFF: holdoff <= wr_img[15:0];
				`OFS_DECIM: decim <= wr_img[11:0];
				`OFS_SIG_GAIN: sig_gain <= wr_img[11:0];
				`OFS_ERR_THR: err_thr <= wr_img[11:0];
				`OFS_AVG_SCALE: avg_scale <= wr_img[5:0];
				`OFS_POLE: pole <= wr_img[7:0];
				`OFS_REQ_LEVEL: req_level <= wr_img[7:0];
				`OFS_GAIN_HIGH: k_high <= wr_img[7:0];
				`OFS_GAIN_LOW: k_low <= wr_img[7:0];
				default: ;
			endcase
		end
	end

	// Sync-now is a pulse, never stored
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sync_now <= 1'b0;
		else
			sync_now <= wr_ctl & wr_img[`CTL_SYNC_NOW]; // RULE_05
	end

	// ----------------------------------------
	// Sync source selection
	// ----------------------------------------
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic [3:0] pin_prev;

	// Two-stage pin synchroniser, then edge memory
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
			pin_prev <= 4'h0;
		end
		else
		begin
			pin_meta <= sync_pin_i;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	wire [3:0] pin_rise = pin_sync & ~pin_prev;
	wire pin_event = pin_rise[ctrl.pin_sel]; // RULE_02
	wire chan_req = ctrl.chan_sync ? chan_sync_i : pin_event; // RULE_01

	// ----------------------------------------
	// Hold-off counter
	// ----------------------------------------
	gain_loop_pkg::hold_state_t hold_state;
	logic [15:0] hold_cnt;
	wire hold_fire = (hold_state == gain_loop_pkg::HOLD_COUNT)
		& (hold_cnt == `HOLDOFF_FIRE + 16'h0001) & ~chan_req; // RULE_10
	wire hold_now = chan_req & (holdoff == `HOLDOFF_FIRE); // RULE_11

	// Count down from the programmed value
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hold_state <= gain_loop_pkg::HOLD_IDLE;
			hold_cnt <= 16'h0000;
		end
		else if (chan_req)
		begin
			// Zero never arms; a new request reloads
			hold_cnt <= holdoff; // RULE_19
			hold_state <= (holdoff > `HOLDOFF_FIRE) ?
				gain_loop_pkg::HOLD_COUNT : gain_loop_pkg::HOLD_IDLE; // RULE_11
		end
		else
		begin
			unique case (hold_state)
				gain_loop_pkg::HOLD_IDLE: hold_cnt <= hold_cnt;
				gain_loop_pkg::HOLD_COUNT:
				begin
					hold_cnt <= hold_cnt - 16'h0001; // RULE_10
					if (hold_cnt == `HOLDOFF_FIRE + 16'h0001)
						hold_state <= gain_loop_pkg::HOLD_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Loop synchronisation
	// ----------------------------------------
	wire sync_req = sync_now | hold_fire | hold_now;
	wire loop_sync = sync_req & ~(ctrl.first_only & synced_once); // RULE_08
	wire loop_init = loop_sync & ctrl.init_sync; // RULE_06

	// Remember the first accepted sync
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			synced_once <= 1'b0;
		else if (loop_sync | (wr_ctl & ~wr_img[`CTL_FIRST_ONLY]))
			synced_once <= loop_sync; // A sync beats a clear
	end

	// ----------------------------------------
	// Active loop parameters
	// ----------------------------------------
	wire upd_fire;
	wire [11:0] next_gain;
	gain_loop_pkg::loop_par_t act;
	wire gain_loop_pkg::loop_par_t fresh = '{decim: decim,
		avg_cnt: avg_scale[`AVG_CNT_HI:`AVG_CNT_LO],
		scale: avg_scale[`AVG_SCALE_HI:`AVG_SCALE_LO],
		gain: sig_gain, k_high: k_high, k_low: k_low, pole: pole};

	// Loop parameters change only on initialisation; the gain also steps on each update
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			act <= fresh;
		else if (loop_init)
			act <= fresh; // RULE_06 RULE_16 RULE_18
		else if (upd_fire)
			act.gain <= next_gain;
	end

	// ----------------------------------------
	// Power averaging and decimation
	// ----------------------------------------
	logic [1:0] avg_cnt;
	logic [11:0] dec_cnt;
	logic [23:0] acc;
	logic [16:0] avg_sum;
	logic [15:0] peak;
	wire [16:0] pwr = {1'b0, mag(sample_i.i)} + {1'b0, mag(sample_i.q)};
	wire avg_done = sample_valid_i & (avg_cnt == act.avg_cnt); // RULE_15
	wire dec_done = avg_done & (dec_cnt == act.decim); // RULE_12
	assign upd_fire = dec_done | loop_sync; // RULE_07
	wire [23:0] scaled = acc << act.scale; // RULE_15
	wire [15:0] avg_lvl = scaled[23:8];

	// Averaging counter and decimation counter
	always_ff @(posedge clk_i)
	begin
		if (rst_i | loop_sync)
		begin
			avg_cnt <= 2'h0;
			dec_cnt <= 12'h000; // RULE_07
		end
		else if (sample_valid_i)
		begin
			avg_cnt <= avg_done ? 2'h0 : avg_cnt + 2'h1;
			if (avg_done)
				dec_cnt <= dec_done ? 12'h000 : dec_cnt + 12'h001;
		end
	end

	// Accumulation of averaged power and peak
	always_ff @(posedge clk_i)
	begin
		if (rst_i | loop_init | (upd_fire & ~loop_sync))
		begin
			acc <= 24'h000000; // RULE_06
			avg_sum <= 17'h00000;
			peak <= 16'h0000;
		end
		else if (sample_valid_i)
		begin
			avg_sum <= avg_done ? 17'h00000 : avg_sum + pwr;
			if (avg_done)
				acc <= acc + {7'h00, avg_sum + pwr};
			if (pwr[16:1] > peak)
				peak <= pwr[16:1];
		end
	end

	// ----------------------------------------
	// Gain update
	// ----------------------------------------
	wire [15:0] target = {req_level, 8'h00};
	wire [15:0] meas = ctrl.mode ? avg_lvl : peak; // RULE_04
	wire above = meas > target;
	wire [15:0] err = above ? meas - target : target - meas;
	wire k_low_sel = err[15:4] < err_thr; // RULE_14
	wire [7:0] k_sel = k_low_sel ? act.k_low : act.k_high; // RULE_14
	wire [11:0] step = {4'h0, k_sel};
	assign next_gain = above ?
		((act.gain > step) ? act.gain - step : 12'h000) :
		((act.gain < 12'hfff - step) ? act.gain + step : 12'hfff);

	// ----------------------------------------
	// Output word
	// ----------------------------------------
	wire [3:0] shift = ctrl.bypass ? 4'h0 : act.gain[11:8]; // RULE_09
	wire [15:0] gi = 16'($signed(sample_i.i) <<< shift);
	wire [15:0] gq = 16'($signed(sample_i.q) <<< shift);

	// Gain-shaped and truncated sample
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sample_o <= '0;
			sample_valid_o <= 1'b0;
		end
		else
		begin
			sample_o.i <= trunc(gi, ctrl.word_len); // RULE_03
			sample_o.q <= trunc(gq, ctrl.word_len); // RULE_03
			sample_valid_o <= sample_valid_i;
		end
	end

	// Strength sample on each update or sync
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			strength_o <= 16'h0000;
			strength_valid_o <= 1'b0;
			loop_sync_o <= 1'b0;
		end
		else
		begin
			if (upd_fire)
				strength_o <= meas; // RULE_05
			strength_valid_o <= upd_fire; // RULE_07
			loop_sync_o <= loop_sync;
		end
	end

	// ----------------------------------------
	// Read mux and acknowledge
	// ----------------------------------------
	always_comb
	begin
		unique case (wb_adr_i)
			`OFS_CONTROL: rd_mux = {21'h0, ctrl};
			`OFS_HOLDOFF: rd_mux = {16'h0, holdoff};
			`OFS_DECIM: rd_mux = {20'h0, decim};
			`OFS_SIG_GAIN: rd_mux = {20'h0, sig_gain};
			`OFS_ERR_THR: rd_mux = {20'h0, err_thr};
			`OFS_AVG_SCALE: rd_mux = {26'h0, avg_scale};
			`OFS_POLE: rd_mux = {24'h0, pole};
			`OFS_REQ_LEVEL: rd_mux = {24'h0, req_level};
			`OFS_GAIN_HIGH: rd_mux = {24'h0, k_high};
			`OFS_GAIN_LOW: rd_mux = {24'h0, k_low};
			`OFS_STATUS: rd_mux = {12'h0, act.gain, 6'h0,
				hold_state == gain_loop_pkg::HOLD_COUNT, synced_once};
			`OFS_STRENGTH: rd_mux = {16'h0, strength_o};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// One-wait-state answer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
		end
	end

endmodule // channel_agc_sync_control

// *** verification/channel_agc_sync_control_asserts.sv ***
// Port checks for the gain loop control block
`timescale 1ns/1ps
`include "gain_loop_regs.svh"
module channel_agc_sync_control_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [3:0] sync_pin_i,
	input wire logic chan_sync_i,
	input wire gain_loop_pkg::iq_t sample_i,
	input wire logic sample_valid_i,
	input wire gain_loop_pkg::iq_t sample_o,
	input wire logic sample_valid_o,
	input wire logic [15:0] strength_o,
	input wire logic strength_valid_o,
	input wire logic loop_sync_o
);
	// ----------------------------------------
	// Shadow of the control low byte
	// ----------------------------------------
	logic [7:0] ctl;
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// A write lands at the edge that samples ack high
	wire wr_ctl = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
		&& wb_adr_i == `OFS_CONTROL && wb_sel_i[0];
	wire now_req = wr_ctl && wb_dat_i[3] && !wb_dat_i[1];
	wire [15:0] m = keep(ctl[7:5]);

	// Mask of the kept top bits
	function automatic logic [15:0] keep(input logic [2:0] wl);
		int w;
		w = (wl == 3'd0) ? 16 : (wl == 3'd1) ? 12 : (wl == 3'd2) ? 10 : 11 - wl;
		return 16'hffff << (16 - w);
	endfunction

	// Track control writes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctl <= 8'h00;
		else if (wr_ctl)
			ctl <= wb_dat_i[7:0];
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_follows: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_sync_now: assert property (now_req |-> ##[1:3] loop_sync_o)
		else $error("sync now gave no loop sync");
	a_sync_strength: assert property (loop_sync_o |-> strength_valid_o)
		else $error("loop sync without strength sample");
	a_valid_delay: assert property (sample_valid_i |=> sample_valid_o)
		else $error("sample valid not delayed by one");
	a_trunc_low: assert property (sample_valid_o
		|-> ((sample_o.i | sample_o.q) & ~m) == 16'h0)
		else $error("low bits not truncated");
	a_bypass_pass: assert property (sample_valid_o && ctl[0]
		|-> sample_o == ($past(sample_i) & {m, m}))
		else $error("bypass output differs from input");
	a_strength_hold: assert property (!strength_valid_o |-> $stable(strength_o))
		else $error("strength changed without update");

	c_loop_sync: cover property (loop_sync_o);
	c_bypass: cover property (sample_valid_o && ctl[0]);
	c_write: cover property (take && wb_we_i);
endmodule // channel_agc_sync_control_asserts

bind channel_agc_sync_control channel_agc_sync_control_asserts
	u_channel_agc_sync_control_asserts (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_pin_i(sync_pin_i),
	.chan_sync_i(chan_sync_i), .sample_i(sample_i),
	.sample_valid_i(sample_valid_i), .sample_o(sample_o),
	.sample_valid_o(sample_valid_o), .strength_o(strength_o),
	.strength_valid_o(strength_valid_o), .loop_sync_o(loop_sync_o));

// *** verification/upstream_chain_model.sv ***
// Upstream chain model: samples, channel sync and sync pins
`timescale 1ns/1ps
module upstream_chain_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic send_i,
	input wire gain_loop_pkg::iq_t data_i,
	input wire logic chan_req_i,
	input wire logic [3:0] pin_req_i,
	output gain_loop_pkg::iq_t sample_o,
	output logic sample_valid_o,
	output logic chan_sync_o,
	output logic [3:0] sync_pin_o
);
	// Launch one edge later; idle data keeps toggling
	always_ff @(posedge clk_i)
	begin
		sample_valid_o <= send_i;
		sample_o <= rst_i ? '0 : send_i ? data_i : ~sample_o;
		chan_sync_o <= chan_req_i;
		sync_pin_o <= pin_req_i;
	end
endmodule // upstream_chain_model

// *** verification/tb_top.sv ***
// Self-checking bench for the gain loop control block
`timescale 1ns/1ps
`include "gain_loop_regs.svh"
module tb_top;
	logic clk_i, rst_i, cyc, stb, we, ack, send, chan_req, sv, sv_o, ch;
	logic loop_sync, str_v;
	logic [7:0] adr;
	logic [3:0] sel, pin_req, pins;
	logic [31:0] dat_w, dat_r, rdata;
	logic [15:0] strength, m;
	gain_loop_pkg::iq_t din, smp, sout;
	int mismatches = 0, check_count = 0, syncs = 0, base = 0;
	int cyc_n = 0, t0 = 0, lat = 0, w;
	logic [7:0] ofs [9] = '{`OFS_HOLDOFF, `OFS_DECIM, `OFS_SIG_GAIN,
		`OFS_ERR_THR, `OFS_AVG_SCALE, `OFS_POLE, `OFS_REQ_LEVEL,
		`OFS_GAIN_HIGH, `OFS_GAIN_LOW};
	logic [31:0] msk [9] = '{32'hffff, 32'hfff, 32'hfff, 32'hfff, 32'h3f,
		32'hff, 32'hff, 32'hff, 32'hff};

	channel_agc_sync_control u_channel_agc_sync_control (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(rdata),
		.wb_ack_o(ack), .sync_pin_i(pins), .chan_sync_i(ch),
		.sample_i(smp), .sample_valid_i(sv), .sample_o(sout),
		.sample_valid_o(sv_o), .strength_o(strength),
		.strength_valid_o(str_v), .loop_sync_o(loop_sync));
	upstream_chain_model u_upstream_chain_model (.clk_i(clk_i),
		.rst_i(rst_i), .send_i(send), .data_i(din), .chan_req_i(chan_req),
		.pin_req_i(pin_req), .sample_o(smp), .sample_valid_o(sv),
		.chan_sync_o(ch), .sync_pin_o(pins));

	// ----------------------------------------
	// Clock, sync counting and tasks
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Count loop syncs and their delay from channel sync
	always @(posedge clk_i)
	begin
		cyc_n <= cyc_n + 1;
		if (ch)
			t0 <= cyc_n;
		if (loop_sync)
			{syncs, lat} <= {syncs + 1, cyc_n - t0};
	end

	task automatic chk(input string nm, input logic [31:0] e, got);
		check_count++;
		if (got !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, got);
		end
	endtask

	task automatic wb(input logic w_en, input logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		{cyc, stb, we, adr, sel, dat_w} <= {2'b11, w_en, a, 4'hf, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 50)
			mismatches++;
		dat_r = rdata;
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, dat_r);
	endtask

	task automatic fire(input logic c, input logic [3:0] p);
		{chan_req, pin_req} <= {c, p};
		@(posedge clk_i);
		{chan_req, pin_req} <= 5'h0;
		@(posedge clk_i);
	endtask

	task automatic sy(input int n);
		repeat (40) @(posedge clk_i);
		chk("syncs", n, syncs - base);
		base = syncs;
	endtask

	task automatic hold(input logic [15:0] n, input int ns);
		wb(1'b1, `OFS_HOLDOFF, {16'h0, n});
		fire(1'b1, 4'h0);
		sy(ns);
		if (ns > 0)
			chk("latency", {16'h0, n}, lat);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		#200000;
		mismatches++;
		results();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		rst_i = 1'b1;
		{cyc, stb, we, send, chan_req} = 5'h0;
		{adr, sel, pin_req, dat_w, din} = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values, widths and an unmapped place
		foreach (ofs[k])
		begin
			rd(ofs[k], (k == 0) ? 32'h1 : 32'h0, "reset value");
			wb(1'b1, ofs[k], 32'hffffffff);
			rd(ofs[k], msk[k], "width");
		end
		wb(1'b1, 8'h40, 32'hffffffff);
		rd(8'h40, 32'h0, "unmapped");
		rd(`OFS_STATUS, 32'h0, "gain before init");
		// Word length with bypass
		for (int wl = 0; wl < 8; wl++)
		begin
			w = (wl == 0) ? 16 : (wl == 1) ? 12 : (wl == 2) ? 10 : 11 - wl;
			m = 16'hffff << (16 - w);
			wb(1'b1, `OFS_CONTROL, {24'h0, wl[2:0], 5'h01});
			{send, din} <= {1'b1, 32'hfedca987};
			@(posedge clk_i);
			send <= 1'b0;
			repeat (2) @(posedge clk_i);
			chk("valid", 32'h1, {31'h0, sv_o});
			chk("sample", {16'hfedc & m, 16'ha987 & m}, sout);
		end
		// Channel sync through the hold-off counter
		wb(1'b1, `OFS_CONTROL, 32'h400);
		hold(16'h1, 1);
		hold(16'h5, 1);
		hold(16'h0, 0);
		wb(1'b1, `OFS_HOLDOFF, 32'h8);
		fire(1'b1, 4'h0);
		repeat (2) @(posedge clk_i);
		fire(1'b1, 4'h0);
		sy(1);
		chk("reload latency", 32'h8, lat);
		// Pin selection; channel sync then ignored
		wb(1'b1, `OFS_HOLDOFF, 32'h1);
		for (int p = 0; p < 4; p++)
		begin
			wb(1'b1, `OFS_CONTROL, {22'h0, p[1:0], 8'h0});
			fire(1'b0, 4'hf ^ (4'h1 << p));
			sy(0);
			fire(1'b0, 4'h1 << p);
			sy(1);
			fire(1'b1, 4'h0);
			sy(0);
		end
		// First sync only, then every sync
		wb(1'b1, `OFS_CONTROL, 32'h400);
		wb(1'b1, `OFS_CONTROL, 32'h402);
		repeat (3) fire(1'b1, 4'h0);
		sy(1);
		wb(1'b1, `OFS_CONTROL, 32'h400);
		repeat (2) fire(1'b1, 4'h0);
		sy(2);
		// Sync now ignores a blocking hold-off
		wb(1'b1, `OFS_HOLDOFF, 32'h0);
		wb(1'b1, `OFS_CONTROL, 32'h01c);
		sy(1);
		rd(`OFS_CONTROL, 32'h014, "sync now self clear");
		rd(`OFS_STATUS, 32'h000fff01, "status after init");
		results();
	end
endmodule // tb_top
